/* hdl/gprdm_pkg.sv */
package gprdm_pkg;

  localparam int GPRDM_NUM_GPR_LEGACY = 8;
  localparam int GPRDM_NUM_GPR_WIDE = 16;
  localparam int GPRDM_NUM_SEG = 6;
  localparam int GPRDM_SEG_W = 16;
  localparam int GPRDM_NARROW_W = 32;
  localparam int GPRDM_WIDE_W = 64;
  localparam int GPRDM_CTRL_NUM = 8;
  localparam int GPRDM_DBG_NUM = 8;

  localparam logic [63:0] GPRDM_FLAGS_RESET = 64'h0000_0000_0000_0002;
  localparam logic [63:0] GPRDM_IP_RESET = 64'h0000_0000_0000_0000;

  // Flag bit positions within flags_reg
  localparam int GPRDM_CARRY_BIT = 0;
  localparam int GPRDM_PARITY_BIT = 2;
  localparam int GPRDM_ZERO_BIT = 6;
  localparam int GPRDM_SIGN_BIT = 7;
  localparam int GPRDM_OVERFLOW_BIT = 11;

  // Operand size codes
  typedef enum logic [1:0] {
    GPRDM_SZ_BYTE = 2'h0,
    GPRDM_SZ_WORD = 2'h1,
    GPRDM_SZ_DWORD = 2'h2,
    GPRDM_SZ_QWORD = 2'h3
  } gprdm_size_t;

  // Operand location kinds
  typedef enum logic [2:0] {
    GPRDM_LOC_GPR = 3'h0,
    GPRDM_LOC_SEG = 3'h1,
    GPRDM_LOC_MEM = 3'h2,
    GPRDM_LOC_CTRL = 3'h3,
    GPRDM_LOC_DBG = 3'h4,
    GPRDM_LOC_IMM = 3'h5
  } gprdm_loc_t;

  typedef enum logic [1:0] {
    GPRDM_OP_NONE = 2'h0,
    GPRDM_OP_PLAIN_MOVE = 2'h1,
    GPRDM_OP_CONDITIONAL_MOVE = 2'h2
  } gprdm_op_t;

  // Condition nibble: one code per aliased pair
  localparam logic [3:0] GPRDM_CC_O = 4'h0;
  localparam logic [3:0] GPRDM_CC_NO = 4'h1;
  localparam logic [3:0] GPRDM_CC_B = 4'h2;
  localparam logic [3:0] GPRDM_CC_AE = 4'h3;
  localparam logic [3:0] GPRDM_CC_E = 4'h4;
  localparam logic [3:0] GPRDM_CC_NE = 4'h5;
  localparam logic [3:0] GPRDM_CC_BE = 4'h6;
  localparam logic [3:0] GPRDM_CC_A = 4'h7;
  localparam logic [3:0] GPRDM_CC_S = 4'h8;
  localparam logic [3:0] GPRDM_CC_NS = 4'h9;
  localparam logic [3:0] GPRDM_CC_P = 4'ha;
  localparam logic [3:0] GPRDM_CC_NP = 4'hb;
  localparam logic [3:0] GPRDM_CC_L = 4'hc;
  localparam logic [3:0] GPRDM_CC_GE = 4'hd;
  localparam logic [3:0] GPRDM_CC_LE = 4'he;
  localparam logic [3:0] GPRDM_CC_G = 4'hf;

  typedef struct packed {
    logic valid;
    gprdm_op_t op;
    gprdm_loc_t src_kind;
    gprdm_loc_t dst_kind;
    logic [3:0] src_idx;
    logic [3:0] dst_idx;
    gprdm_size_t size;
    logic ext_prefix;
    logic [3:0] cond;
    logic [63:0] imm;
  } gprdm_req_t;

  typedef struct packed {
    logic done;
    logic illegal;
    logic moved;
    logic mem_wr;
    logic [63:0] mem_wdata;
  } gprdm_rsp_t;

endpackage

/* hdl/gprdm_cond_eval.sv */
`timescale 1ns/1ps
module gprdm_cond_eval (
  // Condition and flags
  input wire logic [3:0] cond_in,
  input wire logic [63:0] flags_in,
  // Result
  output logic take_out
);
  import gprdm_pkg::*;

  logic carry_flag;
  logic zero_flag;
  logic sign_flag;
  logic overflow_flag;
  logic parity_flag;

  always_comb begin
    carry_flag = flags_in[GPRDM_CARRY_BIT];
    zero_flag = flags_in[GPRDM_ZERO_BIT];
    sign_flag = flags_in[GPRDM_SIGN_BIT];
    overflow_flag = flags_in[GPRDM_OVERFLOW_BIT];
    parity_flag = flags_in[GPRDM_PARITY_BIT];
    // Alias pairs share one code, so they decode identically
    case (cond_in)
      GPRDM_CC_O: take_out = overflow_flag;
      GPRDM_CC_NO: take_out = !overflow_flag;
      GPRDM_CC_B: take_out = carry_flag;
      GPRDM_CC_AE: take_out = !carry_flag;
      GPRDM_CC_E: take_out = zero_flag;
      GPRDM_CC_NE: take_out = !zero_flag;
      GPRDM_CC_BE: take_out = carry_flag | zero_flag;
      GPRDM_CC_A: take_out = !(carry_flag | zero_flag);
      GPRDM_CC_S: take_out = sign_flag;
      GPRDM_CC_NS: take_out = !sign_flag;
      GPRDM_CC_P: take_out = parity_flag;
      GPRDM_CC_NP: take_out = !parity_flag;
      GPRDM_CC_L: take_out = sign_flag ^ overflow_flag;
      GPRDM_CC_GE: take_out = !(sign_flag ^ overflow_flag);
      GPRDM_CC_LE: take_out = (sign_flag ^ overflow_flag) | zero_flag;
      GPRDM_CC_G: take_out = !((sign_flag ^ overflow_flag) | zero_flag);
      default: take_out = 1'b0;
    endcase
  end
endmodule

/* hdl/gprdm_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - Outside 64-bit mode, eight 32-bit general registers serve data and addressing.
// - Six 16-bit segment selector registers are kept.
// - Outside 64-bit mode the flags register is 32 bits.
// - Outside 64-bit mode the instruction pointer loads 32 bits; upper bits held from 64-bit mode stay visible.
// - 64-bit mode gives sixteen registers; upper eight and 64-bit width need prefix.
// - In 64-bit mode the flags register is 64 bits wide.
// - In 64-bit mode the instruction pointer is 64 bits wide.
// - 64-bit mode supports byte to quadword operands, chosen by size selection.
// - Plain move supports memory, general, segment, control, debug, immediate paths.
// - Plain move refuses memory-to-memory and segment-to-segment transfers.
// - Conditional move writes only when its condition holds on current flags.
// - Conditional move takes 16 or 32-bit operands, general destination only.
// - Aliased condition names decode to one identical test.
// - Conditional move support is reported as a feature bit.
// - Conditions test carry/zero, sign xor overflow, parity, overflow, sign.
module gprdm_core #(
  parameter logic CMOV_SUPPORTED = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Mode
  input wire logic long_mode_in,
  // Request from sequencer
  input wire gprdm_pkg::gprdm_req_t req_in,
  input wire logic [63:0] mem_rdata_in,
  // Flag and pointer updates from other units
  input wire logic flags_we_in,
  input wire logic [63:0] flags_in,
  input wire logic ip_we_in,
  input wire logic [63:0] ip_in,
  // Response
  output gprdm_pkg::gprdm_rsp_t rsp_out,
  // Architectural state view
  output logic [63:0] flags_reg_out,
  output logic [63:0] instr_pointer_out,
  output logic [3:0] gpr_sel_unused_out,
  // Feature information
  output logic cmov_feature_out
);
  import gprdm_pkg::*;

  typedef struct packed {
    logic [GPRDM_NUM_GPR_WIDE-1:0][GPRDM_WIDE_W-1:0] gpr;
    logic [GPRDM_NUM_SEG-1:0][GPRDM_SEG_W-1:0] seg;
    logic [GPRDM_CTRL_NUM-1:0][GPRDM_WIDE_W-1:0] ctrl;
    logic [GPRDM_DBG_NUM-1:0][GPRDM_WIDE_W-1:0] dbg;
    logic [GPRDM_WIDE_W-1:0] flags;
    logic [GPRDM_WIDE_W-1:0] ip;
    gprdm_rsp_t rsp;
    logic feature;
    // Outward copies, so every output leaves a flop
    logic [GPRDM_WIDE_W-1:0] flags_view;
    logic [3:0] sel;
  } gprdm_state_t;

  gprdm_state_t state_reg;
  gprdm_state_t state_next;
  logic cond_take;
  logic [63:0] src_val;
  logic [63:0] size_mask;
  logic src_ok;
  logic dst_ok;
  logic legal;
  logic [63:0] wval;

  gprdm_cond_eval u_cond (
    .cond_in(req_in.cond),
    .flags_in(state_reg.flags),
    .take_out(cond_take)
  );

  // True when a general index is reachable in the current mode
  function automatic logic gpr_reach(input logic [3:0] idx, input logic lm, input logic ext);
    gpr_reach = (idx < 4'(GPRDM_NUM_GPR_LEGACY)) || (lm && ext);
  endfunction

  always_comb begin
    state_next = state_reg;
    // Response fields are one-cycle pulses
    state_next.rsp = '0;
    state_next.feature = CMOV_SUPPORTED;
    src_val = '0;
    src_ok = 1'b0;
    dst_ok = 1'b0;
    legal = 1'b0;
    // Effective width: quadword only in long mode with prefix
    case (req_in.size)
      GPRDM_SZ_BYTE: size_mask = 64'h0000_0000_0000_00ff;
      GPRDM_SZ_WORD: size_mask = 64'h0000_0000_0000_ffff;
      GPRDM_SZ_DWORD: size_mask = 64'h0000_0000_ffff_ffff;
      GPRDM_SZ_QWORD: size_mask = 64'hffff_ffff_ffff_ffff;
      default: size_mask = 64'h0000_0000_0000_0000;
    endcase
    case (req_in.src_kind)
      GPRDM_LOC_GPR: begin
        src_ok = gpr_reach(req_in.src_idx, long_mode_in, req_in.ext_prefix);
        src_val = state_reg.gpr[req_in.src_idx];
      end
      GPRDM_LOC_SEG: begin
        // Selectors read back zero-extended
        src_ok = req_in.src_idx < 4'(GPRDM_NUM_SEG);
        src_val = 64'(state_reg.seg[3'(req_in.src_idx)]);
      end
      GPRDM_LOC_CTRL: begin
        src_ok = req_in.src_idx < 4'(GPRDM_CTRL_NUM);
        src_val = state_reg.ctrl[3'(req_in.src_idx)];
      end
      GPRDM_LOC_DBG: begin
        src_ok = req_in.src_idx < 4'(GPRDM_DBG_NUM);
        src_val = state_reg.dbg[3'(req_in.src_idx)];
      end
      GPRDM_LOC_MEM: begin
        // Memory answers in the request cycle, no wait states
        src_ok = 1'b1;
        src_val = mem_rdata_in;
      end
      GPRDM_LOC_IMM: begin
        src_ok = 1'b1;
        src_val = req_in.imm;
      end
      default: src_ok = 1'b0;
    endcase
    case (req_in.dst_kind)
      GPRDM_LOC_GPR: dst_ok = gpr_reach(req_in.dst_idx, long_mode_in, req_in.ext_prefix);
      GPRDM_LOC_SEG: dst_ok = req_in.dst_idx < 4'(GPRDM_NUM_SEG);
      GPRDM_LOC_CTRL: dst_ok = req_in.dst_idx < 4'(GPRDM_CTRL_NUM);
      GPRDM_LOC_DBG: dst_ok = req_in.dst_idx < 4'(GPRDM_DBG_NUM);
      GPRDM_LOC_MEM: dst_ok = 1'b1;
      default: dst_ok = 1'b0;
    endcase
    // Quadword needs long mode and the extension prefix
    if (req_in.size == GPRDM_SZ_QWORD && !(long_mode_in && req_in.ext_prefix)) begin
      src_ok = 1'b0;
    end
    if (req_in.op == GPRDM_OP_PLAIN_MOVE) begin
      case (req_in.dst_kind)
        GPRDM_LOC_GPR: legal = 1'b1;
        GPRDM_LOC_MEM: legal = req_in.src_kind inside {GPRDM_LOC_GPR, GPRDM_LOC_SEG,
                                                      GPRDM_LOC_IMM};
        GPRDM_LOC_SEG: legal = req_in.src_kind inside {GPRDM_LOC_GPR, GPRDM_LOC_MEM};
        GPRDM_LOC_CTRL, GPRDM_LOC_DBG: legal = req_in.src_kind == GPRDM_LOC_GPR;
        default: legal = 1'b0;
      endcase
      // Segment registers carry selectors only, word sized
      if ((req_in.dst_kind == GPRDM_LOC_SEG) && (req_in.size != GPRDM_SZ_WORD)) begin
        legal = 1'b0;
      end
    end else if (req_in.op == GPRDM_OP_CONDITIONAL_MOVE) begin
      // Byte and quadword forms are refused here
      legal = CMOV_SUPPORTED && (req_in.dst_kind == GPRDM_LOC_GPR) &&
              (req_in.src_kind inside {GPRDM_LOC_GPR, GPRDM_LOC_MEM}) &&
              (req_in.size inside {GPRDM_SZ_WORD, GPRDM_SZ_DWORD});
    end
    // A refused request leaves every register untouched except the sel echo
    legal = legal && src_ok && dst_ok;
    wval = src_val & size_mask;
    if (req_in.valid && req_in.op != GPRDM_OP_NONE) begin
      state_next.rsp.done = 1'b1;
      state_next.rsp.illegal = !legal;
      if (legal && (req_in.op == GPRDM_OP_PLAIN_MOVE || cond_take)) begin
        state_next.rsp.moved = 1'b1;
        case (req_in.dst_kind)
          GPRDM_LOC_GPR: begin
            // Narrow writes merge into the untouched upper bits
            state_next.gpr[req_in.dst_idx] =
              (state_reg.gpr[req_in.dst_idx] & ~size_mask) | wval;
          end
          GPRDM_LOC_SEG: state_next.seg[3'(req_in.dst_idx)] = wval[GPRDM_SEG_W-1:0];
          GPRDM_LOC_CTRL: state_next.ctrl[3'(req_in.dst_idx)] = wval;
          GPRDM_LOC_DBG: state_next.dbg[3'(req_in.dst_idx)] = wval;
          GPRDM_LOC_MEM: begin
            state_next.rsp.mem_wr = 1'b1;
            state_next.rsp.mem_wdata = wval;
          end
          default: state_next.rsp.moved = 1'b0;
        endcase
      end
    end
    // Width of flags and pointer follows the mode
    if (flags_we_in) begin
      if (long_mode_in) begin
        state_next.flags = flags_in;
      end else begin
        state_next.flags = {32'h0000_0000, flags_in[GPRDM_NARROW_W-1:0]};
      end
    end
    if (ip_we_in) begin
      if (long_mode_in) begin
        state_next.ip = ip_in;
      end else begin
        state_next.ip = {32'h0000_0000, ip_in[GPRDM_NARROW_W-1:0]};
      end
    end
    // Held upper flags survive a drop to legacy mode but stay hidden
    if (long_mode_in) begin
      state_next.flags_view = state_next.flags;
    end else begin
      state_next.flags_view = {32'h0000_0000, state_next.flags[GPRDM_NARROW_W-1:0]};
    end
    // Debug echo of the last destination index
    state_next.sel = req_in.dst_idx;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '0;
      state_reg.flags <= GPRDM_FLAGS_RESET;
      state_reg.ip <= GPRDM_IP_RESET;
      state_reg.flags_view <= GPRDM_FLAGS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp_out = state_reg.rsp;
  assign flags_reg_out = state_reg.flags_view;
  assign instr_pointer_out = state_reg.ip;
  assign gpr_sel_unused_out = state_reg.sel;
  assign cmov_feature_out = state_reg.feature;
endmodule

/* tb/gprdm_core_assertions.sv */
`timescale 1ns/1ps
module gprdm_core_checker #(
  parameter logic CMOV_SUPPORTED = 1'b1
) (
  // Clock, reset, mode
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic long_mode_in,
  // Inputs of the core
  input wire gprdm_pkg::gprdm_req_t req_in,
  input wire logic [63:0] mem_rdata_in,
  input wire logic flags_we_in,
  input wire logic [63:0] flags_in,
  input wire logic ip_we_in,
  input wire logic [63:0] ip_in,
  // Outputs of the core
  input wire gprdm_pkg::gprdm_rsp_t rsp_out,
  input wire logic [63:0] flags_reg_out,
  input wire logic [63:0] instr_pointer_out,
  input wire logic [3:0] gpr_sel_unused_out,
  input wire logic cmov_feature_out
);
  import gprdm_pkg::*;
  logic tk;
  logic gate;
  assign tk = req_in.valid && req_in.op != GPRDM_OP_NONE;
  assign gate = long_mode_in && req_in.ext_prefix;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  done_on_take_a: assert property (tk |=> rsp_out.done) else $error("done missing");
  no_spurious_a: assert property (!tk |=> !rsp_out.done) else $error("done without request");
  refuse_quiet_a: assert property (rsp_out.illegal |-> rsp_out.done && !rsp_out.moved
    && !rsp_out.mem_wr) else $error("refused request had effect");
  mem_to_mem_a: assert property (tk && req_in.src_kind == GPRDM_LOC_MEM
    && req_in.dst_kind == GPRDM_LOC_MEM |=> rsp_out.illegal) else $error("mem copy taken");
  seg_to_seg_a: assert property (tk && req_in.src_kind == GPRDM_LOC_SEG
    && req_in.dst_kind == GPRDM_LOC_SEG |=> rsp_out.illegal) else $error("seg copy taken");
  cmov_byte_a: assert property (tk && req_in.op == GPRDM_OP_CONDITIONAL_MOVE
    && req_in.size == GPRDM_SZ_BYTE |=> rsp_out.illegal) else $error("byte cond move taken");
  qword_gate_a: assert property (tk && req_in.size == GPRDM_SZ_QWORD && !gate
    |=> rsp_out.illegal) else $error("qword without prefix taken");
  upper_gpr_a: assert property (tk && req_in.src_kind == GPRDM_LOC_GPR
    && req_in.src_idx[3] && !gate |=> rsp_out.illegal) else $error("upper gpr reached");
  flags_narrow_a: assert property (flags_we_in && !long_mode_in
    |=> flags_reg_out == ($past(flags_in) & 64'hffff_ffff)) else $error("flags not 32 bit");
  flags_wide_a: assert property (flags_we_in && long_mode_in
    |=> flags_reg_out == $past(flags_in)) else $error("flags not 64 bit");
  ip_narrow_a: assert property (ip_we_in && !long_mode_in
    |=> instr_pointer_out == ($past(ip_in) & 64'hffff_ffff)) else $error("ip not 32 bit");
  ip_wide_a: assert property (ip_we_in && long_mode_in
    |=> instr_pointer_out == $past(ip_in)) else $error("ip not 64 bit");
  feature_bit_a: assert property (!$past(rst_in)
    |-> cmov_feature_out == CMOV_SUPPORTED) else $error("feature bit wrong");
  cmov_dst_a: assert property (tk && req_in.op == GPRDM_OP_CONDITIONAL_MOVE
    && req_in.dst_kind != GPRDM_LOC_GPR |=> rsp_out.illegal)
    else $error("cond move to non-gpr taken");
  imm_dst_a: assert property (tk && req_in.dst_kind == GPRDM_LOC_IMM
    |=> rsp_out.illegal) else $error("immediate destination taken");
endmodule
bind gprdm_core gprdm_core_checker #(.CMOV_SUPPORTED(CMOV_SUPPORTED)) chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .long_mode_in(long_mode_in), .req_in(req_in),
  .mem_rdata_in(mem_rdata_in), .flags_we_in(flags_we_in), .flags_in(flags_in),
  .ip_we_in(ip_we_in), .ip_in(ip_in), .rsp_out(rsp_out), .flags_reg_out(flags_reg_out),
  .instr_pointer_out(instr_pointer_out), .gpr_sel_unused_out(gpr_sel_unused_out),
  .cmov_feature_out(cmov_feature_out));

/* tb/gprdm_mem_model.sv */
`timescale 1ns/1ps
module gprdm_mem_model (
  // Bus side
  input wire logic core_clk_in,
  input wire gprdm_pkg::gprdm_req_t req_in,
  input wire gprdm_pkg::gprdm_rsp_t rsp_in,
  input wire logic [63:0] word_in,
  // Memory answers
  output logic [63:0] mem_rdata_out,
  output logic [63:0] last_wr_out
);
  import gprdm_pkg::*;
  logic [63:0] last_wr = 64'h0;
  // Off-cycle data inverted so a stray read cannot match by luck
  assign mem_rdata_out = (req_in.valid && req_in.src_kind == GPRDM_LOC_MEM) ? word_in
    : ~last_wr;
  assign last_wr_out = last_wr;
  always @(posedge core_clk_in) begin
    if (rsp_in.mem_wr) begin
      last_wr <= rsp_in.mem_wdata;
    end
  end
endmodule

/* tb/gp_register_data_move_tb.sv */
`timescale 1ns/1ps
module gp_register_data_move_tb;
  import gprdm_pkg::*;
  logic core_clk_in = 0, rst_in = 1, long_mode_in = 0, flags_we_in = 0, ip_we_in = 0;
  logic [63:0] flags_in = 0, ip_in = 0, mem_rdata, last_wr, flags_q, ip_q;
  logic [3:0] sel_q;
  logic feat;
  gprdm_req_t req = '0;
  gprdm_rsp_t rsp, got;
  int fails = 0, checked = 0;
  always #25 core_clk_in = ~core_clk_in;
  gprdm_core #(.CMOV_SUPPORTED(1'b1)) uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .long_mode_in(long_mode_in), .req_in(req), .mem_rdata_in(mem_rdata),
    .flags_we_in(flags_we_in), .flags_in(flags_in), .ip_we_in(ip_we_in), .ip_in(ip_in),
    .rsp_out(rsp), .flags_reg_out(flags_q), .instr_pointer_out(ip_q),
    .gpr_sel_unused_out(sel_q), .cmov_feature_out(feat));
  gprdm_mem_model mem (.core_clk_in(core_clk_in), .req_in(req), .rsp_in(rsp),
    .word_in(64'h1234_5678_9abc_def0), .mem_rdata_out(mem_rdata), .last_wr_out(last_wr));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task summarize;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task issue(input gprdm_op_t op, input gprdm_loc_t sk, input gprdm_loc_t dk,
    input logic [3:0] si, input logic [3:0] di, input gprdm_size_t sz,
    input logic [63:0] imm = 64'h0, input logic ext = 1'b0, input logic [3:0] cc = 4'h0);
    req = '{1'b1, op, sk, dk, si, di, sz, ext, cc, imm};
    @(negedge core_clk_in);
    got = rsp;
  endtask
  task st(input logic [3:0] e);
    check({60'h0, got.done, got.illegal, got.moved, got.mem_wr}, {60'h0, e});
  endtask
  task idle;
    req.valid = 1'b0;
    @(negedge core_clk_in);
  endtask
  task load_fi(input logic [63:0] f, input logic [63:0] i);
    {flags_we_in, ip_we_in, flags_in, ip_in} = {2'b11, f, i};
    @(negedge core_clk_in);
    {flags_we_in, ip_we_in} = 2'b00;
  endtask
  function automatic logic take(input logic [63:0] f, input logic [3:0] c);
    logic t;
    case (c[3:1])
      3'h0: t = f[GPRDM_OVERFLOW_BIT];
      3'h1: t = f[GPRDM_CARRY_BIT];
      3'h2: t = f[GPRDM_ZERO_BIT];
      3'h3: t = f[GPRDM_CARRY_BIT] | f[GPRDM_ZERO_BIT];
      3'h4: t = f[GPRDM_SIGN_BIT];
      3'h5: t = f[GPRDM_PARITY_BIT];
      3'h6: t = f[GPRDM_SIGN_BIT] ^ f[GPRDM_OVERFLOW_BIT];
      default: t = (f[GPRDM_SIGN_BIT] ^ f[GPRDM_OVERFLOW_BIT]) | f[GPRDM_ZERO_BIT];
    endcase
    return t ^ c[0];
  endfunction
  task t_moves;
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_IMM, GPRDM_LOC_GPR, 0, 3, GPRDM_SZ_DWORD,
      64'h1111_2222_3333_4444);
    st(4'b1010);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 3, 0, GPRDM_SZ_DWORD);
    check(got.mem_wdata, 64'h3333_4444);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_MEM, GPRDM_LOC_GPR, 0, 5, GPRDM_SZ_WORD);
    st(4'b1010);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 5, 0, GPRDM_SZ_DWORD);
    check(got.mem_wdata, 64'hdef0);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_SEG, 3, 1, GPRDM_SZ_WORD);
    st(4'b1010);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_IMM, GPRDM_LOC_MEM, 0, 0, GPRDM_SZ_DWORD, 64'h1_abcd);
    check(got.mem_wdata, 64'h1_abcd);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_SEG, GPRDM_LOC_MEM, 1, 0, GPRDM_SZ_WORD);
    st(4'b1011);
    idle;
    check(last_wr, 64'h4444);
  endtask
  task t_refuse;
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_MEM, GPRDM_LOC_MEM, 0, 0, GPRDM_SZ_DWORD);
    st(4'b1100);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_SEG, GPRDM_LOC_SEG, 1, 2, GPRDM_SZ_WORD);
    st(4'b1100);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_GPR, 8, 3, GPRDM_SZ_DWORD);
    st(4'b1100);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_IMM, GPRDM_LOC_GPR, 0, 3, GPRDM_SZ_QWORD, 64'h7);
    st(4'b1100);
    issue(GPRDM_OP_CONDITIONAL_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_GPR, 5, 3, GPRDM_SZ_BYTE);
    st(4'b1100);
    issue(GPRDM_OP_CONDITIONAL_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 5, 0, GPRDM_SZ_DWORD);
    st(4'b1100);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_IMM, 3, 0, GPRDM_SZ_DWORD);
    st(4'b1100);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 3, 0, GPRDM_SZ_DWORD);
    check(got.mem_wdata, 64'h3333_4444);
    idle;
  endtask
  task t_cond;
    logic [63:0] pats [3];
    pats = '{64'h2, 64'h8c7, 64'h82};
    foreach (pats[p]) begin
      load_fi(pats[p], 64'h0);
      for (int c = 0; c < 16; c++) begin
        issue(GPRDM_OP_CONDITIONAL_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_GPR, 5, 3, GPRDM_SZ_DWORD,
          64'h0, 1'b0, c[3:0]);
        st({2'b10, take(pats[p], c[3:0]), 1'b0});
      end
      idle;
    end
    load_fi(64'h2, 64'h0);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_IMM, GPRDM_LOC_GPR, 0, 3, GPRDM_SZ_DWORD, 64'h5555);
    issue(GPRDM_OP_CONDITIONAL_MOVE, GPRDM_LOC_MEM, GPRDM_LOC_GPR, 0, 3, GPRDM_SZ_WORD,
      64'h0, 1'b0, GPRDM_CC_E);
    st(4'b1000);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 3, 0, GPRDM_SZ_DWORD);
    check(got.mem_wdata, 64'h5555);
    issue(GPRDM_OP_CONDITIONAL_MOVE, GPRDM_LOC_MEM, GPRDM_LOC_GPR, 0, 3, GPRDM_SZ_WORD,
      64'h0, 1'b0, GPRDM_CC_NE);
    st(4'b1010);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 3, 0, GPRDM_SZ_DWORD);
    check(got.mem_wdata, 64'hdef0);
    idle;
  endtask
  task t_width;
    load_fi(64'h1234_5678_0000_0ac2, 64'h8765_4321_0000_1000);
    check(flags_q, 64'h0ac2);
    check(ip_q, 64'h1000);
    long_mode_in = 1'b1;
    load_fi(64'h1234_5678_0000_0ac2, 64'h8765_4321_0000_1000);
    check(flags_q, 64'h1234_5678_0000_0ac2);
    check(ip_q, 64'h8765_4321_0000_1000);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_IMM, GPRDM_LOC_GPR, 0, 9, GPRDM_SZ_QWORD,
      64'hfedc_ba98_7654_3210, 1'b1);
    st(4'b1010);
    check({60'h0, sel_q}, 64'h9);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 9, 0, GPRDM_SZ_QWORD, 0, 1'b1);
    check(got.mem_wdata, 64'hfedc_ba98_7654_3210);
    issue(GPRDM_OP_PLAIN_MOVE, GPRDM_LOC_GPR, GPRDM_LOC_MEM, 9, 0, GPRDM_SZ_BYTE, 0, 1'b1);
    check(got.mem_wdata, 64'h10);
    idle;
    long_mode_in = 1'b0;
  endtask
  initial begin
    #100000;
    fails++;
    summarize;
  end
  initial begin
    repeat (16) @(negedge core_clk_in);
    check(flags_q, 64'h2);
    check({63'h0, feat}, 64'h0);
    rst_in = 1'b0;
    @(negedge core_clk_in);
    check({63'h0, feat}, 64'h1);
    t_moves;
    t_refuse;
    t_cond;
    t_width;
    summarize;
  end
endmodule
